// ### port_defs.vh
// register map, reset values and field positions of parallel ports 1 to 5
// assumes an 8-bit register address and 8-bit data on the cpu port
`ifndef PORT_DEFS_VH
`define PORT_DEFS_VH

// address width of the register port
`define PORT_ADDR_W 8

// register offsets
`define OFS_PORT1_OUTPUT_LATCH 8'h01
`define OFS_PORT2_OUTPUT_LATCH 8'h02
`define OFS_PORT3_OUTPUT_LATCH 8'h03
`define OFS_PORT4_OUTPUT_LATCH 8'h04
`define OFS_PORT5_OUTPUT_LATCH 8'h05
`define OFS_PORT1_DIRECTION_CONTROL 8'h09
`define OFS_PORT4_DRIVE_SELECT 8'h0a
`define OFS_PORT4_PIN_READBACK 8'h0e
`define OFS_PORT2_PIN_READBACK 8'h10
`define OFS_PORT3_PIN_READBACK 8'h11
`define OFS_PORT5_PIN_READBACK 8'h12
`define OFS_IRQ_STATUS 8'h20
`define OFS_IRQ_MASK 8'h21
`define OFS_PORT_MODE 8'h22

// reset values
`define RST_PORT1_OUTPUT_LATCH 8'h00
`define RST_PORT1_DIRECTION_CONTROL 8'h00
`define RST_PORT2_OUTPUT_LATCH 3'h7
`define RST_PORT3_OUTPUT_LATCH 8'hff
`define RST_PORT4_OUTPUT_LATCH 8'hff
`define RST_PORT4_DRIVE_SELECT 8'h00
`define RST_PORT5_OUTPUT_LATCH 5'h1f
`define RST_IRQ_MASK 2'h0
`define RST_IRQ_STATUS 2'h0
`define RST_PORT_MODE 2'h0

// port mode register fields
`define MODE_DUAL_CLOCK_BIT 0
`define MODE_STOP_BIT 1

// interrupt status fields
`define IRQ_EXT_FALL_BIT 0
`define IRQ_STOP_RELEASE_BIT 1

`endif

// ### parallel_ports.v
// parallel i/o ports 1 to 5 with latches, direction, drive select
// assumes cpu register port on ref_clk_i, pads resolved outside
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "port_defs.vh"

// Notes on behaviour
// - port 1 bit direction: 0 input, 1 output
// - reset clears port 1 direction and latch
// - port 1 output bits read back latch
// - port 1 input bits read back pin level
// - reset sets port 2 latch to ones
// - port 2 reads valid only in bits 2..0
// - dual clock gives port 2 pins 1,2 to oscillator
// - falling edge on port 2 pin 0 sets interrupt
// - stop mode floats port 2 pin 0
// - reset sets port 3 latch to ones
// - ports 2..5 have latch and pin read paths
// - reset sets port 4 latch, clears drive select
// - port 4 select 0 open drain, 1 push pull
// - reset sets port 5 latch to ones
// - port 5 reads valid only in bits 4..0
module parallel_ports #(
  parameter P1_W = 8,
  parameter P2_W = 3,
  parameter P3_W = 8,
  parameter P4_W = 8,
  parameter P5_W = 5
) (
  // clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // cpu register port
  input wire [`PORT_ADDR_W-1:0] addr_i,
  input wire [7:0] wr_data_i,
  input wire wr_en_i,
  input wire rd_en_i,
  output reg [7:0] rd_data_o,
  // interrupt
  output wire irq_o,
  // peripheral function outputs, held high when unused
  input wire [P1_W-1:0] port1_func_out_i,
  input wire [P4_W-1:0] port4_func_out_i,
  input wire [P5_W-1:0] port5_func_out_i,
  // synchronised pin levels for on-chip peripherals
  output wire [P1_W-1:0] port1_pin_level_o,
  output wire [P2_W-1:0] port2_pin_level_o,
  output wire [P4_W-1:0] port4_pin_level_o,
  output wire [P5_W-1:0] port5_pin_level_o,
  // system mode
  output wire dual_clock_mode_o,
  output wire stop_mode_o,
  output wire slow_crystal_enable_o,
  // port 1 pads
  input wire [P1_W-1:0] port1_pin_i,
  output wire [P1_W-1:0] port1_pin_o,
  output wire [P1_W-1:0] port1_pin_oe_o,
  // port 2 pads
  input wire [P2_W-1:0] port2_pin_i,
  output wire [P2_W-1:0] port2_pin_o,
  output wire [P2_W-1:0] port2_pin_oe_o,
  // port 3 pads
  input wire [P3_W-1:0] port3_pin_i,
  output wire [P3_W-1:0] port3_pin_o,
  output wire [P3_W-1:0] port3_pin_oe_o,
  // port 4 pads
  input wire [P4_W-1:0] port4_pin_i,
  output wire [P4_W-1:0] port4_pin_o,
  output wire [P4_W-1:0] port4_pin_oe_o,
  // port 5 pads
  input wire [P5_W-1:0] port5_pin_i,
  output wire [P5_W-1:0] port5_pin_o,
  output wire [P5_W-1:0] port5_pin_oe_o
);

  // total pad count across all five ports
  localparam PIN_W = P1_W + P2_W + P3_W + P4_W + P5_W;

  // software visible state
  reg [P1_W-1:0] port1_output_latch;
  reg [P1_W-1:0] port1_direction_control;
  reg [P2_W-1:0] port2_output_latch;
  reg [P3_W-1:0] port3_output_latch;
  reg [P4_W-1:0] port4_output_latch;
  reg [P4_W-1:0] port4_drive_select;
  reg [P5_W-1:0] port5_output_latch;
  reg [1:0] irq_status;
  reg [1:0] irq_mask;
  reg [1:0] port_mode;

  // pin synchronisers
  reg [PIN_W-1:0] pin_meta;
  reg [PIN_W-1:0] pin_sync;
  reg stop_pin_prev;

  // bus decode
  wire wr_p1_latch;
  wire wr_p1_dir;
  wire wr_p2_latch;
  wire wr_p3_latch;
  wire wr_p4_latch;
  wire wr_p4_sel;
  wire wr_p5_latch;
  wire wr_mask;
  wire wr_mode;
  wire rd_status;

  // split synchronised pins per port
  wire [P1_W-1:0] port1_pin_sync;
  wire [P2_W-1:0] port2_pin_readback;
  wire [P3_W-1:0] port3_pin_readback;
  wire [P4_W-1:0] port4_pin_readback;
  wire [P5_W-1:0] port5_pin_readback;
  wire stop_release_pin;

  // events
  wire ext_fall_evt;
  wire stop_release_evt;
  wire [1:0] irq_set;

  // read mux
  reg [7:0] next_rd_data;
  wire [P1_W-1:0] port1_read_value;

  // drive values
  wire [P1_W-1:0] port1_drive;
  wire [P4_W-1:0] port4_drive;
  wire [P5_W-1:0] port5_drive;
  wire dual_clock;
  wire stop_mode;

  // mode bits as used by the pad logic
  assign dual_clock = port_mode[`MODE_DUAL_CLOCK_BIT];
  assign stop_mode = port_mode[`MODE_STOP_BIT];

  // write strobes per register, and the status read strobe
  assign wr_p1_latch = wr_en_i && (addr_i == `OFS_PORT1_OUTPUT_LATCH);
  assign wr_p1_dir = wr_en_i && (addr_i == `OFS_PORT1_DIRECTION_CONTROL);
  assign wr_p2_latch = wr_en_i && (addr_i == `OFS_PORT2_OUTPUT_LATCH);
  assign wr_p3_latch = wr_en_i && (addr_i == `OFS_PORT3_OUTPUT_LATCH);
  assign wr_p4_latch = wr_en_i && (addr_i == `OFS_PORT4_OUTPUT_LATCH);
  assign wr_p4_sel = wr_en_i && (addr_i == `OFS_PORT4_DRIVE_SELECT);
  assign wr_p5_latch = wr_en_i && (addr_i == `OFS_PORT5_OUTPUT_LATCH);
  assign wr_mask = wr_en_i && (addr_i == `OFS_IRQ_MASK);
  assign wr_mode = wr_en_i && (addr_i == `OFS_PORT_MODE);
  assign rd_status = rd_en_i && (addr_i == `OFS_IRQ_STATUS);

  // two-stage synchroniser over every pad input
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // idle high, so a released pad gives no edge at reset
      pin_meta <= {PIN_W{1'b1}};
      pin_sync <= {PIN_W{1'b1}};
    end else begin
      pin_meta <= {port5_pin_i, port4_pin_i, port3_pin_i,
                   port2_pin_i, port1_pin_i};
      pin_sync <= pin_meta;
    end
  end

  // slices of the synchronised pin vector
  assign port1_pin_sync = pin_sync[P1_W-1:0];
  assign port2_pin_readback = pin_sync[P1_W+P2_W-1:P1_W];
  assign port3_pin_readback = pin_sync[P1_W+P2_W+P3_W-1:P1_W+P2_W];
  assign port4_pin_readback =
    pin_sync[P1_W+P2_W+P3_W+P4_W-1:P1_W+P2_W+P3_W];
  assign port5_pin_readback = pin_sync[PIN_W-1:P1_W+P2_W+P3_W+P4_W];
  assign stop_release_pin = port2_pin_readback[0];

  // pin levels handed to timers, serial, uart and i2c blocks
  assign port1_pin_level_o = port1_pin_sync;
  assign port2_pin_level_o = port2_pin_readback;
  assign port4_pin_level_o = port4_pin_readback;
  assign port5_pin_level_o = port5_pin_readback;

  // port 1 latch and direction
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port1_output_latch <= `RST_PORT1_OUTPUT_LATCH;
      port1_direction_control <= `RST_PORT1_DIRECTION_CONTROL;
    end else begin
      if (wr_p1_latch) begin
        port1_output_latch <= wr_data_i[P1_W-1:0];
      end
      if (wr_p1_dir) begin
        port1_direction_control <= wr_data_i[P1_W-1:0];
      end
    end
  end

  // ports 2 to 5 latches and port 4 drive select
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port2_output_latch <= `RST_PORT2_OUTPUT_LATCH;
      port3_output_latch <= `RST_PORT3_OUTPUT_LATCH;
      port4_output_latch <= `RST_PORT4_OUTPUT_LATCH;
      port4_drive_select <= `RST_PORT4_DRIVE_SELECT;
      port5_output_latch <= `RST_PORT5_OUTPUT_LATCH;
    end else begin
      if (wr_p2_latch) begin
        port2_output_latch <= wr_data_i[P2_W-1:0];
      end
      if (wr_p3_latch) begin
        port3_output_latch <= wr_data_i[P3_W-1:0];
      end
      if (wr_p4_latch) begin
        port4_output_latch <= wr_data_i[P4_W-1:0];
      end
      if (wr_p4_sel) begin
        port4_drive_select <= wr_data_i[P4_W-1:0];
      end
      if (wr_p5_latch) begin
        port5_output_latch <= wr_data_i[P5_W-1:0];
      end
    end
  end

  // stop release falling edge, seen on the pad after the synchroniser
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // matches the synchroniser, so reset shows no fall
      stop_pin_prev <= 1'b1;
    end else begin
      stop_pin_prev <= stop_release_pin;
    end
  end

  // a driven low pulse on pin 0 also reads back, so it interrupts too
  assign ext_fall_evt = stop_pin_prev && !stop_release_pin;
  assign stop_release_evt = ext_fall_evt && stop_mode;
  assign irq_set = {stop_release_evt, ext_fall_evt};

  // mode register; a release edge ends stop mode, over a software write
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_mode <= `RST_PORT_MODE;
    end else begin
      if (wr_mode) begin
        port_mode <= wr_data_i[1:0];
      end
      // last assignment wins, so the release beats a write
      if (stop_release_evt) begin
        port_mode[`MODE_STOP_BIT] <= 1'b0;
      end
    end
  end

  // sticky status, cleared by read; a new event wins over the clear
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_status <= `RST_IRQ_STATUS;
      irq_mask <= `RST_IRQ_MASK;
    end else begin
      // a read keeps only what is set in this cycle
      if (rd_status) begin
        irq_status <= irq_set;
      end else begin
        irq_status <= irq_status | irq_set;
      end
      if (wr_mask) begin
        irq_mask <= wr_data_i[1:0];
      end
    end
  end

  // level interrupt while an unmasked status bit is set
  assign irq_o = |(irq_status & irq_mask);

  // port 1 read: latch for outputs, pad level for inputs
  // so a read-modify-write copies pad levels into input bits
  assign port1_read_value =
    (port1_direction_control & port1_output_latch) |
    (~port1_direction_control & port1_pin_sync);

  // read data mux, unmapped addresses return zero
  always @* begin
    // narrow ports leave their upper bits at zero
    next_rd_data = 8'h00;
    if (addr_i == `OFS_PORT1_OUTPUT_LATCH) begin
      next_rd_data[P1_W-1:0] = port1_read_value;
    end else if (addr_i == `OFS_PORT1_DIRECTION_CONTROL) begin
      next_rd_data[P1_W-1:0] = port1_direction_control;
    end else if (addr_i == `OFS_PORT2_OUTPUT_LATCH) begin
      next_rd_data[P2_W-1:0] = port2_output_latch;
    end else if (addr_i == `OFS_PORT2_PIN_READBACK) begin
      next_rd_data[P2_W-1:0] = port2_pin_readback;
    end else if (addr_i == `OFS_PORT3_OUTPUT_LATCH) begin
      next_rd_data[P3_W-1:0] = port3_output_latch;
    end else if (addr_i == `OFS_PORT3_PIN_READBACK) begin
      next_rd_data[P3_W-1:0] = port3_pin_readback;
    end else if (addr_i == `OFS_PORT4_OUTPUT_LATCH) begin
      next_rd_data[P4_W-1:0] = port4_output_latch;
    end else if (addr_i == `OFS_PORT4_DRIVE_SELECT) begin
      next_rd_data[P4_W-1:0] = port4_drive_select;
    end else if (addr_i == `OFS_PORT4_PIN_READBACK) begin
      next_rd_data[P4_W-1:0] = port4_pin_readback;
    end else if (addr_i == `OFS_PORT5_OUTPUT_LATCH) begin
      next_rd_data[P5_W-1:0] = port5_output_latch;
    end else if (addr_i == `OFS_PORT5_PIN_READBACK) begin
      next_rd_data[P5_W-1:0] = port5_pin_readback;
    end else if (addr_i == `OFS_IRQ_STATUS) begin
      next_rd_data[1:0] = irq_status;
    end else if (addr_i == `OFS_IRQ_MASK) begin
      next_rd_data[1:0] = irq_mask;
    end else if (addr_i == `OFS_PORT_MODE) begin
      next_rd_data[1:0] = port_mode;
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_en_i) begin
      rd_data_o <= next_rd_data;
    end else begin
      rd_data_o <= 8'h00;
    end
  end

  // port 1 push-pull; function output gated by latch, reset to 0
  // a timer output with a zero latch bit would stay low
  assign port1_drive = port1_output_latch & port1_func_out_i;
  assign port1_pin_o = port1_drive;
  assign port1_pin_oe_o = port1_direction_control;

  // port 2 open drain; oscillator pins and stop pin float as noted
  assign port2_pin_o = {P2_W{1'b0}};
  // stop mode releases pin 0 whatever its latch holds
  assign port2_pin_oe_o[0] = ~port2_output_latch[0] & ~stop_mode;
  // the slow oscillator owns pins 1 and 2 in dual clock mode
  assign port2_pin_oe_o[2:1] =
    dual_clock ? 2'b00 : ~port2_output_latch[2:1];
  assign slow_crystal_enable_o = dual_clock;
  assign dual_clock_mode_o = dual_clock;
  assign stop_mode_o = stop_mode;

  // one loop variable for every per-pad stage below
  genvar gi;

  // port 3 open drain high current sink, one stage per pad
  generate
    for (gi = 0; gi < P3_W; gi = gi + 1) begin : g_port3
      // sinks only; a latch 1 leaves the pad to the outside
      assign port3_pin_o[gi] = 1'b0;
      assign port3_pin_oe_o[gi] = ~port3_output_latch[gi];
    end
  endgenerate

  // port 4 per-bit output stage selection
  assign port4_drive = port4_output_latch & port4_func_out_i;
  generate
    for (gi = 0; gi < P4_W; gi = gi + 1) begin : g_port4
      // push-pull drives both levels, open drain only sinks
      assign port4_pin_o[gi] =
        port4_drive_select[gi] ? port4_drive[gi] : 1'b0;
      assign port4_pin_oe_o[gi] =
        port4_drive_select[gi] | ~port4_drive[gi];
    end
  endgenerate

  // port 5 open drain, shared with the i2c bus
  assign port5_drive = port5_output_latch & port5_func_out_i;
  generate
    for (gi = 0; gi < P5_W; gi = gi + 1) begin : g_port5
      // i2c wants a released pad on a 1, never a driven high
      assign port5_pin_o[gi] = 1'b0;
      assign port5_pin_oe_o[gi] = ~port5_drive[gi];
    end
  endgenerate

endmodule // parallel_ports

// ### port_pins_model.sv
// pad network outside the port block
// assumes the bench gives one outside source level per pad
`timescale 1ns/1ps
module port_pins_model (
  // pad drive from the block
  input wire [7:0] port1_pin_o,
  input wire [7:0] port1_pin_oe_o,
  input wire [2:0] port2_pin_o,
  input wire [2:0] port2_pin_oe_o,
  input wire [7:0] port3_pin_o,
  input wire [7:0] port3_pin_oe_o,
  input wire [7:0] port4_pin_o,
  input wire [7:0] port4_pin_oe_o,
  input wire [4:0] port5_pin_o,
  input wire [4:0] port5_pin_oe_o,
  // outside source levels
  input wire [7:0] ext1,
  input wire [2:0] ext2,
  input wire [7:0] ext3,
  input wire [7:0] ext4,
  input wire [4:0] ext5,
  // resolved pad levels
  output wire [7:0] port1_pin_i,
  output wire [2:0] port2_pin_i,
  output wire [7:0] port3_pin_i,
  output wire [7:0] port4_pin_i,
  output wire [4:0] port5_pin_i
);
  // a driving block wins, a released pad follows the outside source
  assign port1_pin_i = port1_pin_oe_o & port1_pin_o | ~port1_pin_oe_o & ext1;
  assign port2_pin_i = port2_pin_oe_o & port2_pin_o | ~port2_pin_oe_o & ext2;
  assign port3_pin_i = port3_pin_oe_o & port3_pin_o | ~port3_pin_oe_o & ext3;
  assign port4_pin_i = port4_pin_oe_o & port4_pin_o | ~port4_pin_oe_o & ext4;
  assign port5_pin_i = port5_pin_oe_o & port5_pin_o | ~port5_pin_oe_o & ext5;
endmodule // port_pins_model

// ### parallel_ports_monitor.sv
// checker for the parallel port block, bound to its ports
// assumes one clock and an active low asynchronous reset
`timescale 1ns/1ps
module parallel_ports_monitor (
  // clock, reset, register port
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire [7:0] addr_i,
  input wire [7:0] wr_data_i,
  input wire wr_en_i,
  input wire rd_en_i,
  input wire [7:0] rd_data_o,
  // pads and modes
  input wire [7:0] port1_func_out_i,
  input wire [7:0] port1_pin_o,
  input wire [7:0] port1_pin_oe_o,
  input wire [2:0] port2_pin_oe_o,
  input wire [7:0] port3_pin_o,
  input wire [7:0] port3_pin_oe_o,
  input wire [7:0] port4_pin_oe_o,
  input wire [4:0] port5_pin_oe_o,
  input wire dual_clock_mode_o,
  input wire stop_mode_o,
  input wire irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // writes, reset values, read paths and pad modes
  property p_dir_w; wr_en_i && addr_i == 8'h09 |=>
    port1_pin_oe_o == $past(wr_data_i); endproperty
  a_dir_w: assert property (p_dir_w) else $error("dir bad");
  property p_rst_p1; $rose(rst_n_i) |->
    port1_pin_oe_o == 8'h00 && port1_pin_o == 8'h00; endproperty
  a_rst_p1: assert property (p_rst_p1) else $error("p1 rst");
  property p_rst_od; $rose(rst_n_i) |-> port2_pin_oe_o == 3'h0 &&
    port3_pin_oe_o == 8'h00 && port4_pin_oe_o == 8'h00 &&
    port5_pin_oe_o == 5'h00; endproperty
  a_rst_od: assert property (p_rst_od) else $error("od rst");
  property p_p1_rd; rd_en_i && addr_i == 8'h01 && port1_func_out_i == 8'hff
    |=> ((rd_data_o ^ $past(port1_pin_o)) & $past(port1_pin_oe_o)) == 8'h00;
  endproperty
  a_p1_rd: assert property (p_p1_rd) else $error("p1 read");
  property p_p2_hi; rd_en_i && (addr_i == 8'h02 || addr_i == 8'h10) |=>
    rd_data_o[7:3] == 5'h00; endproperty
  a_p2_hi: assert property (p_p2_hi) else $error("p2 upper");
  property p_p5_hi; rd_en_i && (addr_i == 8'h05 || addr_i == 8'h12) |=>
    rd_data_o[7:5] == 3'h0; endproperty
  a_p5_hi: assert property (p_p5_hi) else $error("p5 upper");
  property p_stop; stop_mode_o |-> !port2_pin_oe_o[0]; endproperty
  a_stop: assert property (p_stop) else $error("stop pad");
  property p_dual; dual_clock_mode_o |-> port2_pin_oe_o[2:1] == 2'h0;
  endproperty
  a_dual: assert property (p_dual) else $error("osc pads");
  property p_p4_sel; wr_en_i && addr_i == 8'h0a |=>
    (port4_pin_oe_o & $past(wr_data_i)) == $past(wr_data_i); endproperty
  a_p4_sel: assert property (p_p4_sel) else $error("p4 sel");
  property p_od; wr_en_i && addr_i == 8'h03 |=> port3_pin_o == 8'h00 &&
    port3_pin_oe_o == ~$past(wr_data_i); endproperty
  a_od: assert property (p_od) else $error("p3 od");
  property p_rd_idle; !rd_en_i |=> rd_data_o == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rd idle");
  // main scenarios reached
  c_irq: cover property (irq_o);
  c_stop: cover property (stop_mode_o);
  c_dual: cover property (dual_clock_mode_o);
endmodule // parallel_ports_monitor
bind parallel_ports parallel_ports_monitor mon (.*);

// ### tb_top.sv
// self-checking bench for the parallel port block
// assumes the pad model closes the loop from pads back to the block
`timescale 1ns/1ps
module tb_top;
  // clock, reset, register port
  logic ref_clk_i = 0, rst_n_i = 0, wr_en_i = 0, rd_en_i = 0;
  logic [7:0] addr_i = 0, wr_data_i = 0, rd_data_o, last_rd;
  logic irq_o, dual_clock_mode_o, stop_mode_o, slow_crystal_enable_o;
  // function outputs, pads and outside sources
  logic [7:0] port1_func_out_i = 8'hff, port4_func_out_i = 8'hff;
  logic [4:0] port5_func_out_i = 5'h1f, ext5 = 5'h1f;
  logic [7:0] ext1 = 8'hff, ext3 = 8'hff, ext4 = 8'hff;
  logic [2:0] ext2 = 3'h7;
  logic [7:0] port1_pin_i, port1_pin_o, port1_pin_oe_o, port1_pin_level_o;
  logic [2:0] port2_pin_i, port2_pin_o, port2_pin_oe_o, port2_pin_level_o;
  logic [7:0] port3_pin_i, port3_pin_o, port3_pin_oe_o;
  logic [7:0] port4_pin_i, port4_pin_o, port4_pin_oe_o, port4_pin_level_o;
  logic [4:0] port5_pin_i, port5_pin_o, port5_pin_oe_o, port5_pin_level_o;
  int num_errors = 0, num_checks = 0;
  parallel_ports dut (.*);
  port_pins_model pads (.*);
  // 200 MHz clock
  always #2.5 ref_clk_i = ~ref_clk_i;
  // compare and count
  task automatic chk(input string w, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, d);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'h1;
    @(posedge ref_clk_i);
    wr_en_i <= 1'h0;
    @(posedge ref_clk_i);
  endtask
  // one-cycle read strobe, data checked in the following cycle
  task automatic rdc(input logic [7:0] a, e, input string w);
    addr_i <= a;
    rd_en_i <= 1'h1;
    @(posedge ref_clk_i);
    rd_en_i <= 1'h0;
    #1 last_rd = rd_data_o;
    chk(w, e, last_rd);
    @(posedge ref_clk_i);
  endtask
  task automatic do_reset;
    rst_n_i <= 1'h0;
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'h1;
    @(posedge ref_clk_i);
  endtask
  task automatic s_reset;
    chk("p1 oe", 8'h00, port1_pin_oe_o);
    rdc(8'h09, 8'h00, "p1 dir");
    rdc(8'h04, 8'hff, "p4 latch");
    rdc(8'h0a, 8'h00, "p4 sel");
    rdc(8'h03, 8'hff, "p3 latch");
    rdc(8'h02, 8'h07, "p2 latch");
    rdc(8'h05, 8'h1f, "p5 latch");
    wr(8'h30, 8'h5a);
    rdc(8'h30, 8'h00, "unmapped");
    wr(8'h09, 8'hff);
    rdc(8'h01, 8'h00, "p1 latch");
  endtask
  task automatic s_port1;
    ext1 <= 8'h3c;
    wr(8'h01, 8'ha5);
    wr(8'h09, 8'h0f);
    chk("p1 oe", 8'h0f, port1_pin_oe_o);
    chk("p1 out", 8'ha5, port1_pin_o);
    repeat (3) @(posedge ref_clk_i);
    rdc(8'h01, 8'h35, "p1 mixed");
    chk("p1 level", 8'h35, port1_pin_level_o);
    wr(8'h01, last_rd);
    wr(8'h09, 8'hff);
    rdc(8'h01, 8'h35, "p1 rmw");
    wr(8'h01, 8'h02);
    port1_func_out_i <= 8'hfd;
    @(posedge ref_clk_i);
    chk("p1 func", 8'h00, port1_pin_o);
    port1_func_out_i <= 8'hff;
    @(posedge ref_clk_i);
  endtask
  task automatic s_ports;
    ext3 <= 8'hf0;
    wr(8'h03, 8'h3c);
    wr(8'h02, 8'h05);
    wr(8'h05, 8'h15);
    wr(8'h04, 8'h0f);
    repeat (3) @(posedge ref_clk_i);
    rdc(8'h11, 8'h30, "p3 pins");
    rdc(8'h03, 8'h3c, "p3 latch");
    rdc(8'h10, 8'h05, "p2 pins");
    rdc(8'h12, 8'h15, "p5 pins");
    chk("p5 level", 8'h15, {3'h0, port5_pin_level_o});
    chk("p2 level", 8'h05, {5'h00, port2_pin_level_o});
    rdc(8'h0e, 8'h0f, "p4 od pins");
    chk("p4 od oe", 8'hf0, port4_pin_oe_o);
    wr(8'h0a, 8'hff);
    chk("p4 pp oe", 8'hff, port4_pin_oe_o);
    chk("p4 pp out", 8'h0f, port4_pin_o);
    wr(8'h04, 8'hff);
    wr(8'h0a, 8'h00);
    ext4 <= 8'h3c;
    repeat (3) @(posedge ref_clk_i);
    rdc(8'h0e, 8'h3c, "p4 input");
    chk("p4 level", 8'h3c, port4_pin_level_o);
    port4_func_out_i <= 8'hfe;
    port5_func_out_i <= 5'h1e;
    @(posedge ref_clk_i);
    chk("p4 func oe", 8'h01, port4_pin_oe_o);
    chk("p5 func oe", 8'h0b, {3'h0, port5_pin_oe_o});
    chk("p5 out", 8'h00, {3'h0, port5_pin_o});
    port4_func_out_i <= 8'hff;
    port5_func_out_i <= 5'h1f;
    @(posedge ref_clk_i);
  endtask
  task automatic s_irq;
    wr(8'h21, 8'h01);
    rdc(8'h20, 8'h00, "status idle");
    wr(8'h02, 8'h04);
    repeat (8) if (irq_o !== 1'h1) @(posedge ref_clk_i);
    chk("irq set", 8'h01, {7'h00, irq_o});
    rdc(8'h20, 8'h01, "status");
    chk("irq clr", 8'h00, {7'h00, irq_o});
    wr(8'h21, 8'h00);
    wr(8'h02, 8'h05);
    repeat (3) @(posedge ref_clk_i);
    wr(8'h02, 8'h04);
    repeat (6) @(posedge ref_clk_i);
    chk("irq masked", 8'h00, {7'h00, irq_o});
    wr(8'h21, 8'h01);
    chk("irq unmask", 8'h01, {7'h00, irq_o});
    rdc(8'h20, 8'h01, "status held");
  endtask
  task automatic s_mode;
    wr(8'h02, 8'h00);
    wr(8'h22, 8'h01);
    chk("osc en", 8'h01, {7'h00, slow_crystal_enable_o});
    chk("p2 dual oe", 8'h01, {5'h00, port2_pin_oe_o});
    chk("p2 out", 8'h00, {5'h00, port2_pin_o});
    wr(8'h22, 8'h03);
    chk("p2 stop oe", 8'h00, {5'h00, port2_pin_oe_o});
    repeat (4) @(posedge ref_clk_i);
    ext2 <= 3'h6;
    repeat (10) if (stop_mode_o !== 1'h0) @(posedge ref_clk_i);
    chk("stop clr", 8'h00, {7'h00, stop_mode_o});
    rdc(8'h22, 8'h01, "mode");
    rdc(8'h20, 8'h03, "stop status");
    ext2 <= 3'h7;
  endtask
  // prints the verdict and ends the run
  task automatic test_done;
    if (num_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // cut a hang short well beyond the expected run
  initial begin
    #20000;
    num_errors++;
    test_done;
  end
  // main sequence, with a second reset in mid-run
  initial begin
    do_reset;
    s_reset;
    s_port1;
    s_ports;
    s_irq;
    s_mode;
    do_reset;
    s_reset;
    test_done;
  end
endmodule // tb_top
